// >>> common/pspd_pkg.sv
// pspd_pkg: constants and carrier types for the psram host port controller.
// assumes a single 50 MHz core clock and an asynchronous psram on the pins.
//
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package pspd_pkg;

    // ----------------------------------------------------------------
    // pin and timing constants
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 20;              // core clock period
    localparam int          ACCESS_MIN_NS   = 80;              // strobe low time, covers 65 ns cycle
    localparam int          ACCESS_CYC      = (ACCESS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          RECOVER_MIN_NS  = 40;              // standby gap between accesses
    localparam int          RECOVER_CYC     = (RECOVER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          ODIS_MAX_NS     = 1000;            // output-disable longest stretch
    localparam int          ODIS_MAX_CYC    = ODIS_MAX_NS / CLK_PERIOD_NS;
    localparam logic [20:0] TOP_ADDR        = 21'h1fffff;      // mode sequence address, sleep key
    localparam logic [20:0] PARTIAL_KEY     = 21'h17ffff;      // partial retention key
    localparam int          KEY_MODE_BIT    = 19;              // bit that tells the modes apart
    localparam int          SEQ_STEPS       = 6;               // accesses in a mode sequence
    localparam logic [15:0] RDATA_RESET     = 16'h0000;        // read word after reset

    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PSPD_OP_READ  = 2'b00,                                  // plain read
        PSPD_OP_WRITE = 2'b01,                                  // plain write
        PSPD_OP_MODE  = 2'b10,                                  // power-down mode program
        PSPD_OP_SLEEP = 2'b11                                   // enter/leave power down
    } pspd_op_e;

    typedef struct packed {
        pspd_op_e    op;                                        // what to do
        logic [20:0] addr;                                      // word address
        logic [15:0] wdata;                                     // write word
        logic [1:0]  laneEnN;                                   // [1] high lane, [0] low lane, low = on
        logic        partial;                                   // mode op: 1 partial, 0 sleep; sleep op: 1 enter
    } pspd_req_s;

    typedef struct packed {
        logic        csN;                                       // chip_select_n
        logic        weN;                                       // write strobe
        logic        oeN;                                       // output enable
        logic        powerKeep;                                 // power_keep_enable
        logic [1:0]  laneEnN;                                   // high/low lane enables
        logic [20:0] addr;                                      // word_address
    } pspd_pins_s;

endpackage

// >>> rtl/pspd_access.sv
// pspd_access: one timed psram access (read or write) on the pins.
// assumes the caller holds req stable while busy and that the pins are idle on entry.
`timescale 1ns/1ps
module pspd_access (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    input  wire logic                 clkEn,
    // request side
    input  wire logic                 start,
    input  wire logic                 isWrite,
    input  wire logic [20:0]          addr,
    input  wire logic [15:0]          wdata,
    input  wire logic [1:0]           laneEnN,
    output logic                      done,
    output logic [15:0]               rdata,
    // pins (power keep handled by the caller)
    output logic                      csN,
    output logic                      weN,
    output logic                      oeN,
    output logic [1:0]                laneOutN,
    output logic [20:0]               addrOut,
    output logic [15:0]               dqOut,
    output logic [15:0]               dqOe,
    input  wire logic [15:0]          dqSync
);
    import pspd_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ACC_IDLE   = 3'b001,                                     // standby, lanes floating
        ACC_STROBE = 3'b010,                                     // strobe low
        ACC_GAP    = 3'b100                                      // standby gap after access
    } pspd_acc_e;

    pspd_acc_e   state, next_state;                              // access phase
    logic [7:0]  cnt, next_cnt;                                  // phase timer
    logic        wr, next_wr;                                    // latched direction
    logic [20:0] next_addrOut;
    logic [15:0] next_dqOut, next_rdata;
    logic [1:0]  next_laneOutN;

    // next-state logic; address stays driven until the next start, past the gap, so it is valid all access
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_wr       = wr;
        next_addrOut  = addrOut;
        next_dqOut    = dqOut;
        next_laneOutN = laneOutN;
        next_rdata    = rdata;
        unique case (state)
            ACC_IDLE: begin
                if (start) begin
                    next_state    = ACC_STROBE;
                    next_cnt      = 8'(ACCESS_CYC);
                    next_wr       = isWrite;
                    next_addrOut  = addr;
                    next_dqOut    = wdata;
                    next_laneOutN = laneEnN;
                end
            end
            ACC_STROBE: begin
                if (cnt == 8'h01) begin
                    next_state = ACC_GAP;
                    next_cnt   = 8'(RECOVER_CYC);
                    // last strobe cycle: data synchronised two cycles back has settled
                    if (!wr) begin
                        next_rdata = dqSync;
                    end
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            ACC_GAP: begin
                // standby between accesses, chip select high
                if (cnt == 8'h01) begin
                    next_state    = ACC_IDLE;
                    next_laneOutN = 2'b11;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= ACC_IDLE;
            cnt      <= 8'h00;
            wr       <= 1'b0;
            addrOut  <= 21'h000000;
            dqOut    <= 16'h0000;
            laneOutN <= 2'b11;
            rdata    <= RDATA_RESET;
        end else if (clkEn) begin
            state    <= next_state;
            cnt      <= next_cnt;
            wr       <= next_wr;
            addrOut  <= next_addrOut;
            dqOut    <= next_dqOut;
            laneOutN <= next_laneOutN;
            rdata    <= next_rdata;
        end
    end

    // pin strobes; output enable stays high through a write
    assign csN  = (state != ACC_STROBE);
    assign weN  = !((state == ACC_STROBE) && wr);
    assign oeN  = !((state == ACC_STROBE) && !wr);
    assign dqOe = {{8{(state == ACC_STROBE) && wr && !laneOutN[1]}},
                   {8{(state == ACC_STROBE) && wr && !laneOutN[0]}}};
    assign done = (state == ACC_GAP) && (cnt == 8'h01) && clkEn;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_oe_steady_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!weN) |-> oeN) else $error("output enable low during write");
    a_gap_after_access: assert property (@(posedge core_clk) disable iff (!arst_n)
        $rose(csN) |-> csN[*2]) else $error("no standby gap");
    a_addr_held: assert property (@(posedge core_clk) disable iff (!arst_n)
        (!csN && !$past(csN)) |-> $stable(addrOut)) else $error("address moved in access");
endmodule

// >>> rtl/pspd_host.sv
// pspd_host: host controller for an asynchronous psram with power-down modes.
// assumes a single requester holding req until ack; dq read path is asynchronous to core_clk.
`timescale 1ns/1ps
module pspd_host (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 arst_n,
    input  wire logic                 clkEn,
    // user request side
    input  wire logic                 reqValid,
    input  wire pspd_pkg::pspd_req_s  req,
    output logic                      reqReady,
    output logic                      ack,
    output logic [15:0]               rdata,
    output logic                      poweredDown,
    output logic                      partialMode,
    // memory pins
    output pspd_pkg::pspd_pins_s      pins,
    output logic [15:0]               dqOut,
    output logic [15:0]               dqOe,
    input  wire logic [15:0]          dqIn
);
    import pspd_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        H_IDLE  = 5'b00001,                                      // waiting for a request
        H_ACC   = 5'b00010,                                      // single read/write
        H_SEQ   = 5'b00100,                                      // mode sequence step
        H_DOWN  = 5'b01000,                                      // powered down
        H_ACK   = 5'b10000                                       // answer to the user
    } pspd_host_e;

    pspd_host_e  state, next_state;                              // controller phase
    logic [2:0]  step, next_step;                                // mode sequence index 0..5
    logic [15:0] first_readback_word, next_first_readback_word;  // word from sequence read one
    logic [15:0] key_read_word, next_key_read_word;              // word from sequence read six
    logic        partial, next_partial;                          // programmed retention mode
    logic        keep, next_keep;                                // power_keep_enable pin
    logic        reqPartial, next_reqPartial;                    // mode being programmed
    logic [15:0] next_rdata;
    logic        next_ack;
    logic [15:0] dqMeta, dqSync;                                 // read path synchroniser
    logic        accStart, accWrite, accDone;
    logic [20:0] accAddr;
    logic [15:0] accWdata, accRdata;
    logic [1:0]  accLaneN;
    logic        accCsN, accWeN, accOeN;
    logic [1:0]  accLaneOutN;
    logic [20:0] accAddrOut;
    logic [7:0]  odisCnt;                                        // output-disable watch counter

    // ----------------------------------------------------------------
    // read data synchroniser, two flops before use
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dqMeta <= 16'h0000;
            dqSync <= 16'h0000;
        end else if (clkEn) begin
            dqMeta <= dqIn;
            dqSync <= dqMeta;
        end
    end

    // ----------------------------------------------------------------
    // access engine
    // ----------------------------------------------------------------
    pspd_access u_access (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .clkEn    (clkEn),
        .start    (accStart),
        .isWrite  (accWrite),
        .addr     (accAddr),
        .wdata    (accWdata),
        .laneEnN  (accLaneN),
        .done     (accDone),
        .rdata    (accRdata),
        .csN      (accCsN),
        .weN      (accWeN),
        .oeN      (accOeN),
        .laneOutN (accLaneOutN),
        .addrOut  (accAddrOut),
        .dqOut    (dqOut),
        .dqOe     (dqOe),
        .dqSync   (dqSync)
    );

    // sequence step decode: 0 read top, 1-4 write top, 5 read key
    always_comb begin
        accStart = 1'b0;
        accWrite = 1'b0;
        accAddr  = req.addr;
        accWdata = req.wdata;
        accLaneN = req.laneEnN;
        if (state == H_ACC) begin
            accStart = 1'b1;
            accWrite = (req.op == PSPD_OP_WRITE);
        end else if (state == H_SEQ) begin
            accStart = 1'b1;
            accLaneN = 2'b00;
            unique case (step)
                3'd0: begin
                    accAddr = TOP_ADDR;
                end
                3'd1, 3'd2: begin
                    accWrite = 1'b1;
                    accAddr  = TOP_ADDR;
                    accWdata = first_readback_word;
                end
                3'd3, 3'd4: begin
                    accWrite = 1'b1;
                    accAddr  = TOP_ADDR;
                    accWdata = 16'h0000;
                end
                3'd5: begin
                    accAddr = reqPartial ? PARTIAL_KEY : TOP_ADDR;
                end
                default: begin
                    accStart = 1'b0;                             // unreachable step code
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // controller next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state               = state;
        next_step                = step;
        next_first_readback_word = first_readback_word;
        next_key_read_word       = key_read_word;
        next_partial             = partial;
        next_keep                = keep;
        next_reqPartial          = reqPartial;
        next_rdata               = rdata;
        next_ack                 = 1'b0;
        unique case (state)
            H_IDLE: begin
                // idle is standby: chip select high, so power down may follow
                if (reqValid) begin
                    unique case (req.op)
                        PSPD_OP_READ, PSPD_OP_WRITE: next_state = H_ACC;
                        PSPD_OP_MODE: begin
                            // meant to run before normal traffic when retention is wanted
                            next_state      = H_SEQ;
                            next_step       = 3'd0;
                            next_reqPartial = req.partial;
                        end
                        PSPD_OP_SLEEP: begin
                            if (req.partial) begin
                                next_keep  = 1'b0;
                                next_state = H_ACK;              // ack, then rest in power down
                            end else begin
                                next_state = H_ACK;
                            end
                        end
                    endcase
                end
            end
            H_ACC: begin
                // engine busy; start stays high through H_ACC but the engine samples it only in idle, so wait for done
                if (accDone) begin
                    next_rdata = accRdata;
                    next_state = H_ACK;
                end
            end
            H_SEQ: begin
                if (accDone) begin
                    if (step == 3'd0) begin
                        next_first_readback_word = accRdata;
                    end
                    if (step == 3'(SEQ_STEPS - 1)) begin
                        next_key_read_word = accRdata;
                        next_partial       = reqPartial;
                        next_rdata         = accRdata;
                        next_state         = H_ACK;
                    end else begin
                        next_step = step + 3'd1;
                    end
                end
            end
            H_DOWN: begin
                // all lanes float, leave on a wake request; sleep mode loses contents
                if (reqValid && (req.op == PSPD_OP_SLEEP) && !req.partial) begin
                    next_keep  = 1'b1;
                    next_state = H_ACK;
                end
            end
            H_ACK: begin
                next_ack   = 1'b1;
                // a power-down entry must not fall back to idle, or requests would reach a sleeping memory
                next_state = keep ? H_IDLE : H_DOWN;
            end
        endcase
    end

    // registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state               <= H_IDLE;
            step                <= 3'd0;
            first_readback_word <= 16'h0000;
            key_read_word       <= 16'h0000;
            partial             <= 1'b0;
            keep                <= 1'b1;
            reqPartial          <= 1'b0;
            rdata               <= RDATA_RESET;
            ack                 <= 1'b0;
        end else if (clkEn) begin
            state               <= next_state;
            step                <= next_step;
            first_readback_word <= next_first_readback_word;
            key_read_word       <= next_key_read_word;
            partial             <= next_partial;
            keep                <= next_keep;
            reqPartial          <= next_reqPartial;
            rdata               <= next_rdata;
            ack                 <= next_ack;
        end
    end

    // pins: access engine strobes only start from H_ACC/H_SEQ, so once busy the
    // request is held by the user until ack
    assign pins.csN       = accCsN | !keep;
    assign pins.weN       = accWeN;
    assign pins.oeN       = accOeN;
    assign pins.powerKeep = keep;
    assign pins.laneEnN   = accLaneOutN;
    assign pins.addr      = accAddrOut;
    assign reqReady       = (state == H_IDLE) || (state == H_DOWN);
    assign poweredDown    = !keep;
    assign partialMode    = partial;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            odisCnt <= 8'h00;
        end else if (!pins.csN && pins.weN && pins.oeN) begin
            odisCnt <= odisCnt + 8'h01;
        end else begin
            odisCnt <= 8'h00;
        end
    end

    a_odis_limit: assert property (@(posedge core_clk) disable iff (!arst_n)
        odisCnt < 8'(ODIS_MAX_CYC)) else $error("output disable too long");
    a_down_standby: assert property (@(posedge core_clk) disable iff (!arst_n)
        $fell(pins.powerKeep) |-> $past(pins.csN)) else $error("power down from active");
    a_down_floats: assert property (@(posedge core_clk) disable iff (!arst_n)
        !pins.powerKeep |-> (dqOe == 16'h0000) && pins.csN) else $error("lanes driven in power down");
    a_lane_write: assert property (@(posedge core_clk) disable iff (!arst_n)
        (dqOe[0] |-> !pins.laneEnN[0]) and (dqOe[8] |-> !pins.laneEnN[1])) else $error("disabled lane driven");
endmodule

// >>> verif/pspd_host_tb_top.sv
// pspd_host_tb_top: self-checking bench for the psram host controller.
// assumes the behavioural psram model sits on the pins.
`timescale 1ns/1ps
module pspd_host_tb_top;
    import pspd_pkg::*;
    typedef struct {pspd_op_e op; logic [20:0] a; logic [15:0] d; logic [1:0] ln; logic [15:0] exp, msk;} pspd_row_s;
    logic        core_clk = 1'b0, arst_n = 1'b0, reqValid = 1'b0;
    logic        reqReady, ack, poweredDown, partialMode, modelErr;
    pspd_req_s   req = '0;
    pspd_pins_s  pins;
    logic [15:0] rdata, dqOut, dqOe, dqIn, mDq;
    int          err_count = 0, samples_checked = 0, cyc = 0;
    // plain accesses: lane masks on writes and reads
    pspd_row_s   rows [6] = '{
        '{PSPD_OP_WRITE, 21'h000010, 16'h1234, 2'b00, 16'h0000, 16'h0000},
        '{PSPD_OP_READ,  21'h000010, 16'h0000, 2'b00, 16'h1234, 16'hffff},
        '{PSPD_OP_WRITE, 21'h000010, 16'habcd, 2'b10, 16'h0000, 16'h0000},
        '{PSPD_OP_READ,  21'h000010, 16'h0000, 2'b00, 16'h12cd, 16'hffff},
        '{PSPD_OP_WRITE, 21'h000020, 16'h5678, 2'b01, 16'h0000, 16'h0000},
        '{PSPD_OP_READ,  21'h000020, 16'h0000, 2'b10, 16'h005a, 16'h00ff}};
    // host wins where it drives; elsewhere the model's value
    assign dqIn = (dqOe & dqOut) | (~dqOe & mDq);
    pspd_host i_dut (.core_clk(core_clk), .arst_n(arst_n), .clkEn(1'b1), .reqValid(reqValid), .req(req),
        .reqReady(reqReady), .ack(ack), .rdata(rdata), .poweredDown(poweredDown), .partialMode(partialMode),
        .pins(pins), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn));
    pspd_psram_model i_mem (.core_clk(core_clk), .pins(pins), .dq(dqIn), .mDq(mDq), .modelErr(modelErr));
    task automatic test_done;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] msk);
        samples_checked++;
        if ((got & msk) !== (exp & msk)) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // hold the request until ack, bounded
    task automatic go(input pspd_op_e op, input logic [20:0] a, input logic [15:0] d, input logic [1:0] ln,
                      input logic p);
        int n;
        @(negedge core_clk);
        req = '{op, a, d, ln, p};
        reqValid = 1'b1;
        for (n = 0; n < 200 && ack !== 1'b1; n++) @(negedge core_clk);
        reqValid = 1'b0;
        if (n == 200) begin
            err_count++;
            $display("[FAIL] %0t no ack", $time);
        end
    endtask
    initial forever #10 core_clk = ~core_clk;
    // hang guard, far above the few hundred cycles needed
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            $display("[FAIL] %0t run timed out", $time);
            test_done();
        end
    end
    initial begin
        repeat (5) @(negedge core_clk);
        chk(rdata, RDATA_RESET, 16'hffff);
        chk({pins.csN, pins.weN, pins.oeN, pins.powerKeep}, 16'h000f, 16'hffff); // idle pins
        chk(partialMode, 16'h0000, 16'hffff); // default sleep
        arst_n = 1'b1;
        foreach (rows[i]) begin
            go(rows[i].op, rows[i].a, rows[i].d, rows[i].ln, 1'b0);
            chk(rdata, rows[i].exp, rows[i].msk); // lane data
        end
        // partial mode keeps the low range only
        go(PSPD_OP_MODE, 21'h0, 16'h0, 2'b00, 1'b1);
        chk(partialMode, 16'h0001, 16'hffff);
        go(PSPD_OP_WRITE, 21'h000030, 16'h1111, 2'b00, 1'b0);
        go(PSPD_OP_WRITE, 21'h100000, 16'h2222, 2'b00, 1'b0);
        go(PSPD_OP_SLEEP, 21'h0, 16'h0, 2'b00, 1'b1);
        chk({poweredDown, pins.powerKeep, dqOe[0]}, 16'h0004, 16'hffff);
        chk(reqReady, 16'h0001, 16'hffff);
        go(PSPD_OP_SLEEP, 21'h0, 16'h0, 2'b00, 1'b0);
        go(PSPD_OP_READ, 21'h000030, 16'h0, 2'b00, 1'b0);
        chk(rdata, 16'h1111, 16'hffff); // retained
        go(PSPD_OP_READ, 21'h100000, 16'h0, 2'b00, 1'b0);
        chk(rdata, 16'h5a5a, 16'hffff); // lost
        // back to sleep mode: nothing kept
        go(PSPD_OP_MODE, 21'h0, 16'h0, 2'b00, 1'b0);
        chk(partialMode, 16'h0000, 16'hffff);
        go(PSPD_OP_SLEEP, 21'h0, 16'h0, 2'b00, 1'b1);
        go(PSPD_OP_SLEEP, 21'h0, 16'h0, 2'b00, 1'b0);
        go(PSPD_OP_READ, 21'h000030, 16'h0, 2'b00, 1'b0);
        chk(rdata, 16'h5a5a, 16'hffff);
        chk(modelErr, 16'h0000, 16'hffff); // sequence order
        // mid-run reset: pins idle, read word cleared, traffic resumes
        arst_n = 1'b0;
        @(negedge core_clk);
        chk({pins.csN, pins.weN, pins.oeN, pins.powerKeep, dqOe[0]}, 16'h001e, 16'hffff);
        chk(rdata, RDATA_RESET, 16'hffff);
        arst_n = 1'b1;
        go(PSPD_OP_WRITE, 21'h000040, 16'hbeef, 2'b00, 1'b0);
        go(PSPD_OP_READ, 21'h000040, 16'h0, 2'b00, 1'b0);
        chk(rdata, 16'hbeef, 16'hffff);
        test_done();
    end
endmodule

// >>> verif/pspd_psram_model.sv
// pspd_psram_model: behavioural psram with power-down mode programming.
// assumes the host drives pins; the bench resolves dq and feeds it back.
`timescale 1ns/1ps
module pspd_psram_model (
    // clock and pins
    input  wire logic                 core_clk,
    input  wire pspd_pkg::pspd_pins_s pins,
    input  wire logic [15:0]          dq,
    // read word, inverse where lanes float
    output logic [15:0]               mDq,
    output logic                      modelErr
);
    import pspd_pkg::*;
    logic [15:0] mem [logic [20:0]];          // sparse store
    logic [15:0] word = 16'h0, key = 16'h0;   // word at addr, first readback
    logic [15:0] wDat = 16'h0;                // last written word
    logic [15:0] cur;                         // stored word at the pins' address, before this edge's write
    logic        part = 1'b0;                 // sleep after power-up
    logic        prevCs = 1'b1, wasW = 1'b0, prevKeep = 1'b1, ok;
    int          step = 0;                    // accesses seen in a sequence
    logic        act;                         // selected and powered
    assign act = pins.powerKeep && !pins.csN;
    // only enabled lanes are driven on a read
    assign mDq[7:0]  = (act && pins.weN && !pins.oeN && !pins.laneEnN[0]) ? word[7:0] : ~word[7:0];
    assign mDq[15:8] = (act && pins.weN && !pins.oeN && !pins.laneEnN[1]) ? word[15:8] : ~word[15:8];
    // lost or unwritten words read as a fixed pattern
    always @(posedge core_clk) begin
        cur       = mem.exists(pins.addr) ? mem[pins.addr] : 16'h5a5a;
        word     <= cur;
        prevCs   <= !act;
        prevKeep <= pins.powerKeep;
        // output enable is ignored while the write strobe is low
        if (act && !pins.weN) begin
            wasW <= 1'b1;
            wDat <= dq;
            mem[pins.addr] = {pins.laneEnN[1] ? cur[15:8] : dq[15:8], pins.laneEnN[0] ? cur[7:0] : dq[7:0]};
        end
        // power-down only from standby; retention per mode
        if (prevKeep && !pins.powerKeep) begin
            if (!pins.csN) modelErr <= 1'b1;
            if (!part) mem.delete();
            else foreach (mem[a]) if (a >= 21'h080000) mem[a] = 16'h5a5a;
        end
        // access ends: step the key sequence
        if (!prevCs && !act) begin
            wasW <= 1'b0;
            ok = wasW && pins.addr == TOP_ADDR && (step > 2 || wDat == key);
            if (step == 0) begin
                step <= (!wasW && pins.addr == TOP_ADDR) ? 1 : 0;
                key  <= word;
            end else if (step < SEQ_STEPS - 1) begin
                step <= ok ? step + 1 : 0;
                if (!ok) modelErr <= 1'b1;
            end else begin
                if (!wasW && pins.addr[20] && pins.addr[18:0] == '1) part <= !pins.addr[KEY_MODE_BIT];
                else modelErr <= 1'b1;
                step <= 0;
            end
        end
    end
    initial modelErr = 1'b0;
endmodule
